// ### flash_cmd_core.sv
// How it works
// RULE1 - resume opcode taken only with suspend set and busy clear
// RULE2 - accepted resume clears suspend now, raises busy, engine finishes job
// RULE3 - resume ignored when suspend clear or busy set
// RULE4 - power loss drops suspend, so a later resume is ignored
// RULE5 - host waits the suspend guard time after resume before suspending
// RULE6 - power-down runs only if chip select rises right after opcode
// RULE7 - low-power state entered within entry time after chip select rises
// RULE8 - in low-power state only the release opcode is acted upon
// RULE9 - after reset the device is awake, never in low-power state
// RULE10 - release opcode then chip select high for release time wakes
// RULE11 - awake release opcode plus three dummy bytes repeats device code
// RULE12 - release with identification waits the shorter release-with-id time
// RULE13 - release opcode ignored while busy, ongoing job untouched
// RULE14 - opcode 90h address zero sends maker code then device code
// RULE15 - address one starts with device code, codes alternate until deselect
// RULE16 - opcode 92h takes address and mode two bits per clock
// RULE17 - host sends mode bits with upper nibble all ones
// RULE18 - opcode 94h four bits per clock, four dummy clocks, four out
// RULE19 - opcode 4Bh plus four dummy bytes sends 64-bit unique number
// RULE20 - suspend opcode taken only with suspend clear and busy set
// RULE21 - bits sampled on rising clock, chip select rise ends instruction
`timescale 1ns/1ps
`include "flash_cmd_consts.svh"
module flash_cmd_core
    import flash_cmd_pkg::*;
#(
    parameter logic [7:0]  MAKER_CODE  = 8'hA5,
    parameter logic [7:0]  DEVICE_CODE = 8'h11,
    parameter logic [63:0] UNIQUE_NUM  = 64'h0123456789ABCDEF
)
(
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    input  wire logic       cs_n_in,
    input  wire logic       sck_in,
    input  wire logic [3:0] io_in,
    output logic      [3:0] io_out,
    output logic      [3:0] io_oe_out,
    input  wire logic       busy_in,
    input  wire logic       power_fail_in,
    output logic            suspend_req_out,
    output logic            resume_req_out,
    output logic            suspend_flag_out,
    output logic            busy_flag_out,
    output logic            low_power_out
);

    // ==========================================================
    // helpers
    function automatic cmd_plan_t decode(input logic [7:0] op,
                                         input logic       asleep,
                                         input logic       waking,
                                         input logic       busy);
        cmd_plan_t p;
        p.first      = ST_IGNORE;
        p.in_w       = `WIDTH_X1;
        p.addr_clks  = 5'h00;
        p.dummy_clks = 6'h00;
        p.out_w      = `WIDTH_X1;
        p.src        = SRC_NONE;
        p.lsb_pos    = `LSB_POS_X1;
        case (op)
            `OP_RESUME, `OP_SUSPEND, `OP_PWR_DOWN: begin
                p.first = ST_TAIL;
            end
            `OP_RELEASE_ID: begin
                p.first      = ST_DUMMY; // [RULE11]
                p.dummy_clks = `DUMMY_RELEASE_ID;
                p.src        = SRC_DEV;
            end
            `OP_ID_X1: begin
                p.first     = ST_ADDR; // [RULE14]
                p.addr_clks = `ADDR_CLKS_X1;
                p.src       = SRC_PAIR;
            end
            `OP_ID_X2: begin
                p.first     = ST_ADDR; // [RULE16]
                p.in_w      = `WIDTH_X2;
                p.addr_clks = `ADDR_CLKS_X2;
                p.out_w     = `WIDTH_X2;
                p.src       = SRC_PAIR;
                p.lsb_pos   = `LSB_POS_MODE;
            end
            `OP_ID_X4: begin
                p.first      = ST_ADDR; // [RULE18]
                p.in_w       = `WIDTH_X4;
                p.addr_clks  = `ADDR_CLKS_X4;
                p.dummy_clks = `DUMMY_X4;
                p.out_w      = `WIDTH_X4;
                p.src        = SRC_PAIR;
                p.lsb_pos    = `LSB_POS_MODE;
            end
            `OP_UNIQUE_ID: begin
                p.first      = ST_DUMMY; // [RULE19]
                p.dummy_clks = `DUMMY_UNIQUE;
                p.src        = SRC_UNIQUE;
            end
            default: begin
                p.first = ST_IGNORE;
            end
        endcase
        if (asleep && op != `OP_RELEASE_ID)
            p.first = ST_IGNORE; // [RULE8]
        if (busy && op == `OP_RELEASE_ID)
            p.first = ST_IGNORE; // [RULE13]
        if (waking)
            p.first = ST_IGNORE; // [RULE10]
        return p;
    endfunction : decode

    function automatic logic [31:0] shift_in(input logic [31:0] sr,
                                             input logic [3:0]  io,
                                             input logic [2:0]  w);
        case (w)
            `WIDTH_X2: shift_in = {sr[29:0], io[1:0]};
            `WIDTH_X4: shift_in = {sr[27:0], io[3:0]};
            default:   shift_in = {sr[30:0], io[0]};
        endcase
    endfunction : shift_in

    function automatic logic [63:0] rotl(input logic [63:0] v,
                                         input logic [2:0]  w);
        case (w)
            `WIDTH_X2: rotl = {v[61:0], v[63:62]};
            `WIDTH_X4: rotl = {v[59:0], v[63:60]};
            default:   rotl = {v[62:0], v[63]};
        endcase
    endfunction : rotl

    function automatic logic [3:0] lane_bits(input logic [63:0] v,
                                             input logic [2:0]  w);
        case (w)
            `WIDTH_X2: lane_bits = {2'h0, v[63:62]};
            `WIDTH_X4: lane_bits = v[63:60];
            default:   lane_bits = {2'h0, v[63], 1'b0};
        endcase
    endfunction : lane_bits

    function automatic logic [3:0] lane_mask(input logic [2:0] w);
        case (w)
            `WIDTH_X2: lane_mask = 4'h3;
            `WIDTH_X4: lane_mask = 4'hF;
            default:   lane_mask = 4'h2;
        endcase
    endfunction : lane_mask

    // ==========================================================
    // pins and timer
    pin_view_t           pins;
    pd_phase_t           pd_phase;
    logic                tmr_start;
    logic [`TIMER_W-1:0] tmr_load;
    logic                tmr_done;

    spi_pin_sync u_sync (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .cs_n_in  (cs_n_in),
        .sck_in   (sck_in),
        .io_in    (io_in),
        .pins_out (pins)
    );

    flash_cmd_timer u_timer (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .start_in (tmr_start),
        .load_in  (tmr_load),
        .done_out (tmr_done)
    );

    // ==========================================================
    // instruction sequencer
    phase_t      state;
    cmd_plan_t   plan;
    cmd_plan_t   next_plan;
    logic [7:0]  op;
    logic [7:0]  next_op;
    logic [5:0]  cnt;
    logic [5:0]  next_cnt;
    logic [31:0] addr_sr;
    logic [31:0] next_addr;
    logic        extra;
    logic        load_out;
    logic        lsb_bit;
    logic        suspend_flag;
    logic        resume_hold;
    logic        busy_flag;

    assign busy_flag = busy_in | resume_hold;
    assign next_op   = {op[6:0], pins.io[0]};
    assign next_cnt  = cnt + 6'h01;
    assign next_addr = shift_in(addr_sr, pins.io, plan.in_w);
    assign next_plan = decode(next_op, pd_phase != PD_AWAKE,
                              pd_phase == PD_WAKING, busy_flag);
    assign lsb_bit   = (state == ST_ADDR) ? next_addr[plan.lsb_pos]
                                          : addr_sr[plan.lsb_pos];
    assign load_out  = pins.sck_rise && !pins.cs_n &&
        ((state == ST_ADDR && next_cnt == {1'b0, plan.addr_clks} &&
          plan.dummy_clks == 6'h00) ||
         (state == ST_DUMMY && next_cnt == plan.dummy_clks));

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state   <= ST_IDLE;
            plan    <= '0;
            op      <= 8'h00;
            cnt     <= 6'h00;
            addr_sr <= 32'h0000_0000;
            extra   <= 1'b0;
        end else if (pins.cs_n) begin
            state <= ST_IDLE; // [RULE21]
        end else if (state == ST_IDLE) begin
            state <= ST_OPCODE;
            cnt   <= 6'h00;
            extra <= 1'b0;
        end else if (pins.sck_rise) begin // [RULE21]
            case (state)
                ST_OPCODE: begin
                    op  <= next_op;
                    cnt <= next_cnt;
                    if (next_cnt == `OPCODE_CLKS) begin
                        plan  <= next_plan;
                        cnt   <= 6'h00;
                        state <= (next_plan.first == ST_ADDR &&
                                  next_plan.addr_clks == 5'h00) ?
                                 ST_DUMMY : next_plan.first;
                    end
                end
                ST_ADDR: begin
                    addr_sr <= next_addr; // [RULE16] [RULE18]
                    cnt     <= next_cnt;
                    if (next_cnt == {1'b0, plan.addr_clks}) begin
                        cnt   <= 6'h00;
                        state <= (plan.dummy_clks != 6'h00) ?
                                 ST_DUMMY : ST_OUT;
                    end
                end
                ST_DUMMY: begin
                    cnt <= next_cnt;
                    if (next_cnt == plan.dummy_clks) begin
                        cnt   <= 6'h00;
                        state <= ST_OUT;
                    end
                end
                ST_TAIL: begin
                    extra <= 1'b1; // [RULE6]
                end
                default: begin
                    state <= state;
                end
            endcase
        end
    end

    // ==========================================================
    // identification shifter, falling clock edges
    logic [63:0] out_sr;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            out_sr <= 64'h0;
            io_out <= 4'h0;
        end else if (load_out) begin
            case (plan.src)
                SRC_DEV:    out_sr <= {8{DEVICE_CODE}}; // [RULE11]
                SRC_PAIR:   out_sr <= lsb_bit ?
                                {4{DEVICE_CODE, MAKER_CODE}} : // [RULE15]
                                {4{MAKER_CODE, DEVICE_CODE}}; // [RULE14]
                SRC_UNIQUE: out_sr <= UNIQUE_NUM; // [RULE19]
                default:    out_sr <= 64'h0;
            endcase
        end else if (pins.sck_fall && !pins.cs_n && state == ST_OUT) begin
            io_out <= lane_bits(out_sr, plan.out_w);
            out_sr <= rotl(out_sr, plan.out_w); // [RULE15]
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in || pins.cs_n)
            io_oe_out <= 4'h0;
        else if (pins.sck_fall && state == ST_OUT)
            io_oe_out <= lane_mask(plan.out_w);
    end

    // ==========================================================
    // actions taken when chip select rises
    logic exec_ok;
    logic resume_ok;
    logic suspend_ok;
    logic pd_go;
    logic release_go;
    logic release_long;

    assign exec_ok    = pins.cs_rise && state == ST_TAIL && !extra; // [RULE6]
    assign resume_ok  = exec_ok && op == `OP_RESUME &&
                        suspend_flag && !busy_flag; // [RULE1] [RULE3]
    assign suspend_ok = exec_ok && op == `OP_SUSPEND &&
                        !suspend_flag && busy_flag; // [RULE20]
    assign pd_go      = exec_ok && op == `OP_PWR_DOWN;
    assign release_go = pins.cs_rise && op == `OP_RELEASE_ID &&
                        (pd_phase == PD_DOWN || pd_phase == PD_ENTERING) &&
                        (state == ST_DUMMY || state == ST_OUT);
    assign release_long = !(state == ST_DUMMY && cnt == 6'h00);

    assign tmr_start = pd_go | release_go;
    assign tmr_load  = !release_go ? `TIMER_W'(`PD_ENTRY_CYC) : // [RULE7]
                       release_long ? `TIMER_W'(`RELEASE_ID_CYC) : // [RULE12]
                       `TIMER_W'(`RELEASE_CYC); // [RULE10]

    // ==========================================================
    // suspend and busy flags
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            suspend_flag    <= 1'b0;
            resume_hold     <= 1'b0;
            suspend_req_out <= 1'b0;
            resume_req_out  <= 1'b0;
        end else begin
            suspend_req_out <= suspend_ok;
            resume_req_out  <= resume_ok; // [RULE2]
            if (power_fail_in)
                suspend_flag <= 1'b0; // [RULE4]
            else if (resume_ok)
                suspend_flag <= 1'b0; // [RULE2]
            else if (suspend_ok)
                suspend_flag <= 1'b1; // [RULE20]
            if (power_fail_in)
                resume_hold <= 1'b0;
            else if (resume_ok)
                resume_hold <= 1'b1; // [RULE2]
            else if (busy_in)
                resume_hold <= 1'b0;
        end
    end

    assign suspend_flag_out = suspend_flag;
    assign busy_flag_out    = busy_flag;

    // ==========================================================
    // low-power state
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pd_phase <= PD_AWAKE; // [RULE9]
        end else if (release_go) begin
            pd_phase <= PD_WAKING; // [RULE10]
        end else if (pd_go) begin
            pd_phase <= PD_ENTERING; // [RULE7]
        end else if (tmr_done) begin
            case (pd_phase)
                PD_ENTERING: pd_phase <= PD_DOWN; // [RULE7]
                PD_WAKING:   pd_phase <= PD_AWAKE; // [RULE12]
                default:     pd_phase <= pd_phase;
            endcase
        end
    end

    assign low_power_out = (pd_phase == PD_DOWN);

endmodule : flash_cmd_core

// ### flash_cmd_consts.svh
`ifndef FLASH_CMD_CONSTS_SVH
`define FLASH_CMD_CONSTS_SVH

// ==========================================================
// opcodes
`define OP_RESUME        8'h7A
`define OP_SUSPEND       8'h75
`define OP_PWR_DOWN      8'hB9
`define OP_RELEASE_ID    8'hAB
`define OP_ID_X1         8'h90
`define OP_ID_X2         8'h92
`define OP_ID_X4         8'h94
`define OP_UNIQUE_ID     8'h4B

// ==========================================================
// instruction shape
`define OPCODE_CLKS      6'h08
`define ADDR_CLKS_X1     5'h18
`define ADDR_CLKS_X2     5'h10
`define ADDR_CLKS_X4     5'h08
`define DUMMY_RELEASE_ID 6'h18
`define DUMMY_X4         6'h04
`define DUMMY_UNIQUE     6'h20
`define LSB_POS_X1       5'h00
`define LSB_POS_MODE     5'h08
`define WIDTH_X1         3'h1
`define WIDTH_X2         3'h2
`define WIDTH_X4         3'h4

// ==========================================================
// timing
`define CLK_MHZ          250
`define PD_ENTRY_NS      3000
`define RELEASE_NS       3000
`define RELEASE_ID_NS    1800
`define TIMER_W          12
`define PD_ENTRY_CYC     ((`PD_ENTRY_NS * `CLK_MHZ) / 1000)
`define RELEASE_CYC      ((`RELEASE_NS * `CLK_MHZ + 999) / 1000)
`define RELEASE_ID_CYC   ((`RELEASE_ID_NS * `CLK_MHZ + 999) / 1000)

`endif

// ### flash_cmd_pkg.sv
package flash_cmd_pkg;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_OPCODE = 3'h1,
        ST_ADDR   = 3'h2,
        ST_DUMMY  = 3'h3,
        ST_OUT    = 3'h4,
        ST_TAIL   = 3'h5,
        ST_IGNORE = 3'h6
    } phase_t;

    typedef enum logic [1:0] {
        SRC_NONE   = 2'h0,
        SRC_DEV    = 2'h1,
        SRC_PAIR   = 2'h2,
        SRC_UNIQUE = 2'h3
    } id_src_t;

    typedef enum logic [1:0] {
        PD_AWAKE    = 2'h0,
        PD_ENTERING = 2'h1,
        PD_DOWN     = 2'h2,
        PD_WAKING   = 2'h3
    } pd_phase_t;

    typedef struct packed {
        phase_t      first;
        logic [2:0]  in_w;
        logic [4:0]  addr_clks;
        logic [5:0]  dummy_clks;
        logic [2:0]  out_w;
        id_src_t     src;
        logic [4:0]  lsb_pos;
    } cmd_plan_t;

    typedef struct packed {
        logic        cs_n;
        logic        cs_rise;
        logic        cs_fall;
        logic        sck_rise;
        logic        sck_fall;
        logic [3:0]  io;
    } pin_view_t;

endpackage : flash_cmd_pkg

// ### spi_pin_sync.sv
`timescale 1ns/1ps
module spi_pin_sync
    import flash_cmd_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    input  wire logic       cs_n_in,
    input  wire logic       sck_in,
    input  wire logic [3:0] io_in,
    output pin_view_t       pins_out
);

    logic [2:0] cs_s;
    logic [2:0] sck_s;
    logic [3:0] io_a;
    logic [3:0] io_b;

    // ==========================================================
    // two-stage synchronisers, third stage for edges
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cs_s  <= 3'h7;
            sck_s <= 3'h0;
            io_a  <= 4'h0;
            io_b  <= 4'h0;
        end else begin
            cs_s  <= {cs_s[1:0], cs_n_in};
            sck_s <= {sck_s[1:0], sck_in};
            io_a  <= io_in;
            io_b  <= io_a;
        end
    end

    assign pins_out.cs_n     = cs_s[1];
    assign pins_out.cs_rise  = cs_s[1] & ~cs_s[2];
    assign pins_out.cs_fall  = ~cs_s[1] & cs_s[2];
    assign pins_out.sck_rise = sck_s[1] & ~sck_s[2];
    assign pins_out.sck_fall = ~sck_s[1] & sck_s[2];
    assign pins_out.io       = io_b;

endmodule : spi_pin_sync

// ### flash_cmd_timer.sv
`timescale 1ns/1ps
`include "flash_cmd_consts.svh"
module flash_cmd_timer
    import flash_cmd_pkg::*;
(
    input  wire logic                clk_in,
    input  wire logic                reset_in,
    input  wire logic                start_in,
    input  wire logic [`TIMER_W-1:0] load_in,
    output logic                     done_out
);

    logic [`TIMER_W-1:0] count;
    logic                running;

    // ==========================================================
    // one-shot down counter, restart on start
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            count    <= '0;
            running  <= 1'b0;
            done_out <= 1'b0;
        end else if (start_in) begin
            count    <= load_in;
            running  <= 1'b1;
            done_out <= 1'b0;
        end else if (running && count <= `TIMER_W'(1)) begin
            running  <= 1'b0;
            done_out <= 1'b1;
        end else begin
            count    <= running ? count - `TIMER_W'(1) : count;
            done_out <= 1'b0;
        end
    end

endmodule : flash_cmd_timer

// ### flash_cmd_core_props.sv
`timescale 1ns/1ps
`include "flash_cmd_consts.svh"
// ==========================================================
// port checker
module flash_cmd_core_props (
    input wire logic       clk_in,
    input wire logic       reset_in,
    input wire logic       cs_n_in,
    input wire logic [3:0] io_oe_out,
    input wire logic       busy_in,
    input wire logic       power_fail_in,
    input wire logic       suspend_req_out,
    input wire logic       resume_req_out,
    input wire logic       suspend_flag_out,
    input wire logic       busy_flag_out,
    input wire logic       low_power_out
);
    logic [11:0] high_cnt;

    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);

    always_ff @(posedge clk_in) begin
        if (reset_in || !cs_n_in) begin
            high_cnt <= 12'h000;
        end else if (high_cnt != 12'hFFF) begin
            high_cnt <= high_cnt + 12'h001;
        end
    end

    sequence s_cs_idle;
        cs_n_in [*8];
    endsequence

    a_reset_awake : assert property (
        $fell(reset_in) |-> !low_power_out && !suspend_flag_out)
        else $error("not awake after reset");
    a_resume_gate : assert property (
        resume_req_out |->
        $past(suspend_flag_out, 2) && !$past(busy_flag_out, 2))
        else $error("bad resume");
    a_resume_effect : assert property (
        resume_req_out |-> !suspend_flag_out && busy_flag_out)
        else $error("resume flags wrong");
    a_suspend_gate : assert property (
        suspend_req_out |->
        $past(busy_flag_out, 2) && !$past(suspend_flag_out, 2))
        else $error("bad suspend");
    a_power_loss : assert property (
        power_fail_in |=> !suspend_flag_out)
        else $error("suspend after loss");
    a_oe_idle : assert property (
        s_cs_idle |-> io_oe_out == 4'h0)
        else $error("drive deselected");
    a_oe_legal : assert property (
        io_oe_out inside {4'h0, 4'h2, 4'h3, 4'hF})
        else $error("bad enable");
    a_entry_time : assert property (
        $rose(low_power_out) |->
        high_cnt >= `PD_ENTRY_CYC && high_cnt <= `PD_ENTRY_CYC + 12)
        else $error("entry time wrong");
    a_busy_follow : assert property (
        $past(busy_in) && busy_in |-> busy_flag_out)
        else $error("busy flag low");
    a_sleep_quiet : assert property (
        low_power_out |-> !resume_req_out && !suspend_req_out)
        else $error("asleep request");
endmodule : flash_cmd_core_props

bind flash_cmd_core flash_cmd_core_props u_props (.*);

// ### spi_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// host controller model
module spi_host_model (
    input  wire logic       clk_in,
    input  wire logic [3:0] bus_in,
    output logic            cs_n_out,
    output logic            sck_out,
    output logic      [3:0] io_out
);
    initial begin
        cs_n_out = 1'b1;
        sck_out  = 1'b0;
        io_out   = 4'h0;
    end

    task automatic half();
        repeat (4) @(negedge clk_in);
    endtask : half

    task automatic shift(input logic [2:0] w, input int n,
                         input logic [31:0] v);
        logic [3:0] m;
        m = (4'h1 << w) - 4'h1;
        repeat (n) begin
            sck_out <= 1'b0;
            io_out  <= ((v[31:28] >> (3'h4 - w)) & m) | (~io_out & ~m);
            v = v << w;
            half();
            sck_out <= 1'b1;
            half();
        end
    endtask : shift

    task automatic recv(input logic [2:0] w, input int n,
                        output logic [63:0] d);
        d = 64'h0;
        repeat (n) begin
            sck_out <= 1'b0;
            io_out  <= ~io_out;
            half();
            sck_out <= 1'b1;
            half();
            d = (d << w) | ((w == 3'h1) ? {63'h0, bus_in[1]} :
                {60'h0, bus_in & ((4'h1 << w) - 4'h1)});
        end
    endtask : recv

    task automatic begin_cmd(input logic [7:0] op);
        cs_n_out <= 1'b0;
        half();
        shift(3'h1, 8, {op, 24'h0});
    endtask : begin_cmd

    task automatic end_cmd();
        sck_out <= 1'b0;
        half();
        cs_n_out <= 1'b1;
        repeat (8) half();
    endtask : end_cmd
endmodule : spi_host_model

// ### flash_cmd_core_tb.sv
`timescale 1ns/1ps
`include "flash_cmd_consts.svh"
module flash_cmd_core_tb;
    localparam logic [7:0]  MAKER  = 8'hA5;
    localparam logic [7:0]  DEV    = 8'h11;
    localparam logic [63:0] UNIQUE = 64'h0123456789ABCDEF;
    logic        clk, rst, cs_n, sck, busy, pfail;
    logic        sus_req, res_req, sus_flag, busy_flag, low_pwr;
    logic [3:0]  host_io, dev_io, dev_oe, bus;
    logic [63:0] d;
    int          failures    = 0;
    int          check_count = 0;
    int          oe_cyc      = 0;
    int          pulses      = 0;

    assign bus = (dev_oe & dev_io) | (~dev_oe & host_io);

    flash_cmd_core #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEV),
        .UNIQUE_NUM(UNIQUE)) u_dut (
        .clk_in(clk), .reset_in(rst), .cs_n_in(cs_n), .sck_in(sck),
        .io_in(bus), .io_out(dev_io), .io_oe_out(dev_oe),
        .busy_in(busy), .power_fail_in(pfail),
        .suspend_req_out(sus_req), .resume_req_out(res_req),
        .suspend_flag_out(sus_flag), .busy_flag_out(busy_flag),
        .low_power_out(low_pwr));

    spi_host_model u_host (.clk_in(clk), .bus_in(bus),
        .cs_n_out(cs_n), .sck_out(sck), .io_out(host_io));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        oe_cyc <= oe_cyc + (dev_oe != 4'h0);
        pulses <= pulses + sus_req + res_req;
    end

    task automatic conclude();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [63:0] got, input logic [63:0] exp,
                         input string what);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t ns: %s", $time, what);
        end
    endtask : check

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle

    task automatic xfer(input logic [7:0] op, input logic [2:0] w,
                        input int na, input logic [31:0] a,
                        input int nd, input int no);
        u_host.begin_cmd(op);
        u_host.shift(w, na, a);
        u_host.shift(w, nd, 32'h0);
        u_host.recv(w, no, d);
        u_host.end_cmd();
    endtask : xfer

    task automatic cmd(input logic [7:0] op);
        xfer(op, 3'h1, 0, 32'h0, 0, 0);
    endtask : cmd

    task automatic sc_id_single();
        for (int a = 0; a < 2; a++) begin
            xfer(`OP_ID_X1, 3'h1, 24, {23'h0, a[0], 8'h0}, 0, 32);
            check(d[31:0], a ? {DEV, MAKER, DEV, MAKER} :
                {MAKER, DEV, MAKER, DEV}, "x1 id");
        end
    endtask : sc_id_single

    task automatic sc_id_wide();
        logic [31:0] m;
        logic [15:0] e;
        for (int a = 0; a < 4; a++) begin
            m = a[0] ? 32'h0000_01F0 : 32'h0000_00F0;
            e = a[0] ? {DEV, MAKER} : {MAKER, DEV};
            if (a < 2)
                xfer(`OP_ID_X2, 3'h2, 16, m, 0, 8);
            else
                xfer(`OP_ID_X4, 3'h4, 8, m, 4, 4);
            check(d[15:0], e, "wide id");
        end
    endtask : sc_id_wide

    task automatic sc_ids();
        int n;
        xfer(`OP_UNIQUE_ID, 3'h1, 0, 32'h0, 32, 64);
        check(d, UNIQUE, "unique number");
        xfer(`OP_RELEASE_ID, 3'h1, 0, 32'h0, 24, 16);
        check(d[15:0], {DEV, DEV}, "device id");
        busy = 1'b1;
        n    = oe_cyc;
        xfer(`OP_RELEASE_ID, 3'h1, 0, 32'h0, 24, 16);
        check(oe_cyc - n, 0, "id read while busy");
        busy = 1'b0;
    endtask : sc_ids

    task automatic sc_resume();
        cmd(`OP_RESUME);
        check(busy_flag, 0, "resume not suspended");
        busy = 1'b1;
        cmd(`OP_SUSPEND);
        check(sus_flag, 1, "suspend");
        cmd(`OP_RESUME);
        check(sus_flag, 1, "resume while busy");
        busy = 1'b0;
        cmd(`OP_RESUME);
        check({sus_flag, busy_flag}, 2'b01, "resume");
        busy = 1'b1;
        idle(100);
        cmd(`OP_SUSPEND);
        busy  = 1'b0;
        pfail = 1'b1;
        idle(1);
        pfail = 1'b0;
        idle(2);
        check(sus_flag, 0, "power loss");
        cmd(`OP_RESUME);
        check(busy_flag, 0, "resume after loss");
        check(pulses, 3, "request pulses");
    endtask : sc_resume

    task automatic sc_powerdown();
        int n;
        u_host.begin_cmd(`OP_PWR_DOWN);
        u_host.shift(3'h1, 1, 32'h0);
        u_host.end_cmd();
        idle(`PD_ENTRY_CYC + 20);
        check(low_pwr, 0, "ninth bit");
        cmd(`OP_PWR_DOWN);
        idle(`PD_ENTRY_CYC);
        check(low_pwr, 1, "power down");
        n = oe_cyc;
        xfer(`OP_ID_X1, 3'h1, 24, 32'h0, 0, 32);
        check(oe_cyc - n, 0, "asleep read");
        check(low_pwr, 1, "asleep stays");
        cmd(`OP_RELEASE_ID);
        idle(`RELEASE_CYC);
        xfer(`OP_ID_X1, 3'h1, 24, 32'h0, 0, 16);
        check({low_pwr, d[15:0]}, {1'b0, MAKER, DEV}, "wake");
        cmd(`OP_PWR_DOWN);
        idle(`PD_ENTRY_CYC);
        xfer(`OP_RELEASE_ID, 3'h1, 0, 32'h0, 24, 16);
        idle(`RELEASE_ID_CYC);
        check(low_pwr, 0, "wake with id");
        xfer(`OP_ID_X1, 3'h1, 24, 32'h0, 0, 16);
        check(d[15:0], {MAKER, DEV}, "after id wake");
    endtask : sc_powerdown

    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        $display("wrong value at %0t ns: watchdog expired", $time);
        conclude();
    end

    initial begin
        rst     = 1'b1;
        busy    = 1'b0;
        pfail   = 1'b0;
        idle(4);
        rst = 1'b0;
        idle(4);
        check({low_pwr, sus_flag}, 2'b00, "reset state");
        sc_id_single();
        sc_id_wide();
        sc_ids();
        sc_resume();
        sc_powerdown();
        conclude();
    end
endmodule : flash_cmd_core_tb
